// file: src/ssirq_pkg.sv
// package of the serial port status / prescale / interrupt register block
// assumes a 32-bit AXI4-Lite register bus and a single 25 MHz system clock
package ssirq_pkg;

    // system clock figures
    localparam int unsigned CLK_HZ        = 25_000_000;  // system clock rate
    localparam int unsigned CLK_PERIOD_NS = 40;          // one clock in ns

    // register byte offsets inside the 4 KiB window
    localparam int unsigned ADDR_W         = 12;
    localparam logic [11:0] OFS_DATA       = 12'h008;  // fifo_data_port
    localparam logic [11:0] OFS_STATUS     = 12'h00c;  // fifo_busy_status
    localparam logic [11:0] OFS_PRESCALE   = 12'h010;  // clock_prescale
    localparam logic [11:0] OFS_MASK       = 12'h014;  // irq_mask
    localparam logic [11:0] OFS_RAW        = 12'h018;  // irq_raw_status
    localparam logic [11:0] OFS_MASKED     = 12'h01c;  // irq_masked_status
    localparam logic [11:0] OFS_CLEAR      = 12'h020;  // irq_clear
    localparam logic [11:0] OFS_IDENT4     = 12'hfd0;  // periph_ident_4
    localparam logic [11:0] OFS_IDENT5     = 12'hfd4;  // periph_ident_5

    // fifo_busy_status field positions
    localparam int unsigned BIT_BUSY       = 4;  // port_active_flag
    localparam int unsigned BIT_RX_FULL    = 3;  // rx_fifo_full_flag
    localparam int unsigned BIT_RX_NE      = 2;  // rx_fifo_has_data
    localparam int unsigned BIT_TX_NF      = 1;  // tx_fifo_has_room
    localparam int unsigned BIT_TX_EMPTY   = 0;  // tx_fifo_empty_flag

    // interrupt source positions, shared by mask, raw, masked and clear
    localparam int unsigned IRQ_TX_LEVEL   = 3;
    localparam int unsigned IRQ_RX_LEVEL   = 2;
    localparam int unsigned IRQ_RX_TIMEOUT = 1;
    localparam int unsigned IRQ_RX_OVERRUN = 0;

    // reset values
    localparam logic [4:0] STATUS_RST      = 5'h03;  // tx empty and has room
    localparam logic [3:0] RAW_RST         = 4'h8;   // tx fifo starts at or below half
    localparam logic [7:0] PRESCALE_RST    = 8'h00;
    localparam logic [3:0] MASK_RST        = 4'h0;

    // prescale and time-out figures
    localparam logic [7:0]  PRESCALE_MIN   = 8'h02;  // smallest usable divisor
    localparam int unsigned TIMEOUT_BITS   = 32;     // idle bit periods before time-out

    // bus responses
    localparam logic [1:0] RESP_OKAY       = 2'b00;
    localparam logic [1:0] RESP_SLVERR     = 2'b10;

endpackage

// file: src/ssirq_prescale.sv
// prescale divider: one-cycle tick every divisor clocks of the system clock
// assumes divisor is even and at least 2; smaller values stop the tick
`timescale 1ns/1ns
module ssirq_prescale (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       run_en,        // port enabled
    input  wire logic [7:0] divisor,       // prescale_divisor, lsb already zero
    // output
    output logic            bit_tick       // serial_bit_clock enable pulse
);

    typedef struct packed {
        logic [7:0] cnt;   // clocks since last tick
        logic       tick;  // registered tick
    } ssirq_pre_s;

    ssirq_pre_s st_ff;
    ssirq_pre_s nxt_st;

    // divide: count 0..divisor-1 and tick on wrap
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (!run_en || divisor < ssirq_pkg::PRESCALE_MIN) begin
            nxt_st.cnt = 8'h00;  // stopped: next start is a full period
        end else if (st_ff.cnt >= divisor - 8'h01) begin
            nxt_st.cnt  = 8'h00;
            nxt_st.tick = 1'b1;  // R6
        end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bit_tick = st_ff.tick;

    // an even divisor of at least two never gives back-to-back ticks
    a_tick_spacing: assert property (  // R6
        @(posedge aclk) disable iff (!aresetn) st_ff.tick |=> !st_ff.tick)
        else $error("prescale tick repeated on consecutive clocks");

endmodule

// file: src/ssirq_timeout.sv
// receive idle timer: counts bit ticks while the receive fifo holds data
// assumes restart pulses on every received frame and every fifo read
`timescale 1ns/1ns
module ssirq_timeout #(
    parameter int unsigned LIMIT = ssirq_pkg::TIMEOUT_BITS  // idle bit periods
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // events
    input  wire logic bit_tick,   // one serial bit period elapsed
    input  wire logic armed,      // receive fifo not empty
    input  wire logic restart,    // frame arrived or entry read
    // output
    output logic      expired     // one-cycle time-out pulse
);

    localparam int unsigned CW = $clog2(LIMIT + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;   // idle bit periods seen
        logic          hit;   // registered expiry pulse
    } ssirq_tmo_s;

    ssirq_tmo_s st_ff;
    ssirq_tmo_s nxt_st;

    // count idle periods; fire once, then hold until the next restart
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.hit = 1'b0;
        if (!armed || restart) begin
            nxt_st.cnt = '0;
        end else if (bit_tick && st_ff.cnt < CW'(LIMIT)) begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
            nxt_st.hit = (st_ff.cnt == CW'(LIMIT - 1));  // R22
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign expired = st_ff.hit;

endmodule

// file: src/ssirq_regs.sv
// register block of the synchronous serial port: status, prescale, interrupts
// assumes the fifos and shifters sit outside and report counts and frame events
// Operation
// [R1] busy while frame in flight or tx holds data
// [R2] rx full flag set when no free entry
// [R3] rx not-empty flag set when entries present
// [R4] tx has-room flag clear only when full
// [R5] tx empty flag set when tx fifo empty
// [R6] prescale value divides system clock for bit timing
// [R7] prescale even, 2..254, lsb reads zero
// [R8] mask bits read back, write sets/clears, reset zero
// [R9] mask bits: 3 tx, 2 rx, 1 timeout, 0 overrun
// [R10] tx raw flag when tx at or below half
// [R11] rx raw flag when rx at or above half
// [R12] timeout raw flag latches on receive time-out
// [R13] overrun raw flag latches on rx overflow
// [R14] raw status readable, writes ignored
// [R15] masked status is raw AND mask, read-only
// [R16] write one to bit 1 clears timeout
// [R17] write one to bit 0 clears overrun
// [R18] ident registers fixed read-only low-byte values
// [R19] software leaves reserved bits alone
// [R20] data read pops rx, write pushes tx
// [R21] overrun when frame arrives into full rx fifo
// [R22] timeout after idle bit periods with rx data
`timescale 1ns/1ns
module ssirq_regs #(
    parameter int unsigned FIFO_DEPTH   = 8,                      // entries per fifo
    parameter int unsigned TIMEOUT_BITS = ssirq_pkg::TIMEOUT_BITS,
    parameter logic [7:0]  IDENT_4      = 8'h5a,                  // arbitrary identity value
    parameter logic [7:0]  IDENT_5      = 8'h3c,                  // arbitrary identity value
    parameter int unsigned CW           = $clog2(FIFO_DEPTH + 1)  // fifo count width
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // axi4-lite write address and data
    input  wire logic [11:0]   awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    // axi4-lite write response
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    // axi4-lite read
    input  wire logic [11:0]   araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    // fifo and shifter side
    input  wire logic          port_enable,      // enable bit of the control register
    input  wire logic          frame_in_flight,  // shifter sending or receiving
    input  wire logic [CW-1:0] tx_fifo_count,
    input  wire logic [CW-1:0] rx_fifo_count,
    input  wire logic [15:0]   rx_fifo_head,     // oldest receive entry
    input  wire logic          rx_frame_done,    // pulse: a complete frame arrived
    output logic               tx_push,          // pulse: write tx_push_data
    output logic [15:0]        tx_push_data,
    output logic               rx_pop,           // pulse: drop oldest rx entry
    output logic               rx_store,         // pulse: keep the arrived frame
    output logic               serial_bit_clock  // prescaled bit-rate enable
);

    localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);
    localparam logic [CW-1:0] HALF_CNT = CW'(FIFO_DEPTH / 2);

    // all state of the block apart from the divider and idle timer
    typedef struct packed {
        logic        awready;   // address slot free
        logic        wready;    // data slot free
        logic        aw_held;   // write address captured
        logic [11:0] aw_addr;
        logic        w_held;    // write data captured
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  prescale;  // prescale_divisor
        logic [3:0]  mask;      // irq_mask
        logic [4:0]  status;    // fifo_busy_status
        logic [3:0]  raw;       // irq_raw_status
        logic        tx_push;
        logic [15:0] tx_data;
        logic        rx_pop;
        logic        rx_store;
    } ssirq_main_s;

    ssirq_main_s st_ff;
    ssirq_main_s nxt_st;

    logic        bit_tick;   // one bit period elapsed
    logic        tmo_hit;    // receive idle time-out pulse
    logic        wr_fire;    // address and data both captured, write performed
    logic        rd_fire;    // read address taken this clock
    logic [3:0]  clr_bits;   // write-one-to-clear strobes
    logic        rx_full;
    logic        ovr_event;  // frame arrived with nowhere to go

    // bit-rate divider, run only while the port is enabled
    ssirq_prescale u_prescale (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run_en   (port_enable),
        .divisor  (st_ff.prescale),  // R6
        .bit_tick (bit_tick)
    );

    // idle timer restarted by each frame and each fifo read
    ssirq_timeout #(  // R22
        .LIMIT (TIMEOUT_BITS)
    ) u_timeout (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .bit_tick (bit_tick),
        .armed    (rx_fifo_count != '0),
        .restart  (rx_frame_done || st_ff.rx_pop),
        .expired  (tmo_hit)
    );

    assign wr_fire   = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    assign rd_fire   = arvalid && st_ff.arready;
    assign rx_full   = (rx_fifo_count >= FULL_CNT);
    assign ovr_event = rx_frame_done && rx_full;  // R21
    assign clr_bits  = (wr_fire && st_ff.aw_addr == ssirq_pkg::OFS_CLEAR && st_ff.w_strb[0])
                       ? st_ff.w_data[3:0] : 4'h0;

    // next state: bus slave, registers, status sampling and event flags
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.tx_push  = 1'b0;
        nxt_st.rx_pop   = 1'b0;
        nxt_st.rx_store = rx_frame_done && !rx_full;  // full fifo drops the frame, keeps entries

        // capture address and data in either order
        if (awvalid && st_ff.awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_addr = awaddr;
        end
        if (wvalid && st_ff.wready) begin
            nxt_st.w_held = 1'b1;
            nxt_st.w_data = wdata;
            nxt_st.w_strb = wstrb;
        end

        // perform the write once both halves are in
        if (wr_fire) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = ssirq_pkg::RESP_OKAY;
            unique case (st_ff.aw_addr)
                ssirq_pkg::OFS_DATA: begin
                    nxt_st.tx_push = 1'b1;  // R20
                    nxt_st.tx_data = st_ff.w_data[15:0];
                end
                ssirq_pkg::OFS_PRESCALE: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.prescale = {st_ff.w_data[7:1], 1'b0};  // R7
                    end
                end
                ssirq_pkg::OFS_MASK: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.mask = st_ff.w_data[3:0];  // R8 R9
                    end
                end
                // read-only and clear registers: writes change no stored value here
                ssirq_pkg::OFS_STATUS, ssirq_pkg::OFS_RAW, ssirq_pkg::OFS_MASKED,
                ssirq_pkg::OFS_CLEAR, ssirq_pkg::OFS_IDENT4, ssirq_pkg::OFS_IDENT5: begin
                    nxt_st.bresp = ssirq_pkg::RESP_OKAY;  // R14 R15 R18
                end
                default: begin
                    nxt_st.bresp = ssirq_pkg::RESP_SLVERR;  // unmapped address
                end
            endcase
        end
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // one write at a time: slots reopen only after the response is taken
        nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
        nxt_st.wready  = !nxt_st.w_held && !nxt_st.bvalid;

        // read: answer with data in the clock after the address is taken
        if (rd_fire) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = ssirq_pkg::RESP_OKAY;
            nxt_st.rdata  = 32'h0000_0000;  // reserved bits read zero
            unique case (araddr)
                ssirq_pkg::OFS_DATA: begin
                    nxt_st.rdata[15:0] = rx_fifo_head;
                    nxt_st.rx_pop      = (rx_fifo_count != '0);  // R20
                end
                ssirq_pkg::OFS_STATUS:   nxt_st.rdata[4:0] = st_ff.status;
                ssirq_pkg::OFS_PRESCALE: nxt_st.rdata[7:0] = st_ff.prescale;
                ssirq_pkg::OFS_MASK:     nxt_st.rdata[3:0] = st_ff.mask;  // R8
                ssirq_pkg::OFS_RAW:      nxt_st.rdata[3:0] = st_ff.raw;  // R14
                ssirq_pkg::OFS_MASKED:   nxt_st.rdata[3:0] = st_ff.raw & st_ff.mask;  // R15
                ssirq_pkg::OFS_CLEAR:    nxt_st.rdata      = 32'h0000_0000;
                ssirq_pkg::OFS_IDENT4:   nxt_st.rdata[7:0] = IDENT_4;  // R18
                ssirq_pkg::OFS_IDENT5:   nxt_st.rdata[7:0] = IDENT_5;  // R18
                default: begin
                    nxt_st.rresp = ssirq_pkg::RESP_SLVERR;  // unmapped address
                end
            endcase
        end
        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end
        nxt_st.arready = !nxt_st.rvalid;

        // fifo and busy status, sampled every clock
        nxt_st.status[ssirq_pkg::BIT_BUSY]     = frame_in_flight || (tx_fifo_count != '0);  // R1
        nxt_st.status[ssirq_pkg::BIT_RX_FULL]  = rx_full;  // R2
        nxt_st.status[ssirq_pkg::BIT_RX_NE]    = (rx_fifo_count != '0);  // R3
        nxt_st.status[ssirq_pkg::BIT_TX_NF]    = (tx_fifo_count < FULL_CNT);  // R4
        nxt_st.status[ssirq_pkg::BIT_TX_EMPTY] = (tx_fifo_count == '0);  // R5

        // level sources follow the fifo counts
        nxt_st.raw[ssirq_pkg::IRQ_TX_LEVEL] = (tx_fifo_count <= HALF_CNT);  // R10
        nxt_st.raw[ssirq_pkg::IRQ_RX_LEVEL] = (rx_fifo_count >= HALF_CNT);  // R11
        // latched sources: a new event beats a clear in the same clock
        nxt_st.raw[ssirq_pkg::IRQ_RX_TIMEOUT] = tmo_hit ||  // R12
            (st_ff.raw[ssirq_pkg::IRQ_RX_TIMEOUT] && !clr_bits[ssirq_pkg::IRQ_RX_TIMEOUT]);  // R16
        nxt_st.raw[ssirq_pkg::IRQ_RX_OVERRUN] = ovr_event ||  // R13
            (st_ff.raw[ssirq_pkg::IRQ_RX_OVERRUN] && !clr_bits[ssirq_pkg::IRQ_RX_OVERRUN]);  // R17
    end

    // state register; reset values make status and tx level read as idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff          <= '0;
            st_ff.awready  <= 1'b1;
            st_ff.wready   <= 1'b1;
            st_ff.arready  <= 1'b1;
            st_ff.prescale <= ssirq_pkg::PRESCALE_RST;
            st_ff.mask     <= ssirq_pkg::MASK_RST;
            st_ff.status   <= ssirq_pkg::STATUS_RST;  // R4 R5
            st_ff.raw      <= ssirq_pkg::RAW_RST;  // R10
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register; serial_bit_clock straight from the divider's tick register
    assign awready          = st_ff.awready;
    assign wready           = st_ff.wready;
    assign bresp            = st_ff.bresp;
    assign bvalid           = st_ff.bvalid;
    assign arready          = st_ff.arready;
    assign rdata            = st_ff.rdata;
    assign rresp            = st_ff.rresp;
    assign rvalid           = st_ff.rvalid;
    assign tx_push          = st_ff.tx_push;
    assign tx_push_data     = st_ff.tx_data;
    assign rx_pop           = st_ff.rx_pop;
    assign rx_store         = st_ff.rx_store;
    assign serial_bit_clock = bit_tick;

    // busy reflects shifter activity or queued transmit data
    a_busy_flag: assert property (  // R1
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> st_ff.status[4] == ($past(frame_in_flight) || $past(tx_fifo_count) != '0))
        else $error("busy flag does not follow activity");

    // receive full and not-empty track the receive count
    a_rx_flags: assert property (  // R2
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> (st_ff.status[3] == ($past(rx_fifo_count) >= FULL_CNT)) &&
                           (st_ff.status[2] == ($past(rx_fifo_count) != '0)))
        else $error("receive fifo flags wrong");

    // transmit room and empty track the transmit count
    a_tx_flags: assert property (  // R4
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> (st_ff.status[1] == ($past(tx_fifo_count) < FULL_CNT)) &&
                           (st_ff.status[0] == ($past(tx_fifo_count) == '0)))
        else $error("transmit fifo flags wrong");

    // divisor never holds an odd value
    a_prescale_even: assert property (  // R7
        @(posedge aclk) disable iff (!aresetn) st_ff.prescale[0] == 1'b0)
        else $error("prescale lsb not zero");

    // a mask write lands one clock later with the written bits
    a_mask_write: assert property (  // R8
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && st_ff.aw_addr == ssirq_pkg::OFS_MASK && st_ff.w_strb[0]
        |=> st_ff.mask == $past(st_ff.w_data[3:0]))
        else $error("mask write not taken");

    // level sources follow the counts against half depth
    a_level_raw: assert property (  // R10
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> (st_ff.raw[3] == ($past(tx_fifo_count) <= HALF_CNT)) &&
                           (st_ff.raw[2] == ($past(rx_fifo_count) >= HALF_CNT)))
        else $error("level interrupt flags wrong");

    // a frame into a full fifo latches overrun and is not stored
    a_overrun_set: assert property (  // R21
        @(posedge aclk) disable iff (!aresetn)
        rx_frame_done && rx_full |=> st_ff.raw[0] && !st_ff.rx_store)
        else $error("overrun not latched");

    // clearing the timeout with no new expiry drops the flag
    a_timeout_clear: assert property (  // R16
        @(posedge aclk) disable iff (!aresetn)
        clr_bits[1] && !tmo_hit |=> !st_ff.raw[1])
        else $error("timeout flag not cleared");

    // masked status read returns raw and mask of the same clock
    a_masked_read: assert property (  // R15
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && araddr == ssirq_pkg::OFS_MASKED |=> rvalid && rdata == {28'h0, $past(st_ff.raw & st_ff.mask)})
        else $error("masked status read wrong");

    // a data read with entries waiting pops exactly once
    a_data_pop: assert property (  // R20
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && araddr == ssirq_pkg::OFS_DATA && rx_fifo_count != '0 |=> rx_pop ##1 !rx_pop)
        else $error("data read did not pop receive fifo");

    // clearing overrun with no new overflow drops the flag
    a_overrun_clear: assert property (  // R17
        @(posedge aclk) disable iff (!aresetn)
        clr_bits[0] && !ovr_event |=> !st_ff.raw[0])
        else $error("overrun flag not cleared");

    // an idle time-out pulse latches the raw flag
    a_timeout_set: assert property (  // R12
        @(posedge aclk) disable iff (!aresetn)
        tmo_hit |=> st_ff.raw[1])
        else $error("timeout flag not latched");

endmodule

// file: verification/ssirq_far.sv
// far-side model: transmit/receive fifo counters and the shifter beside the register block
// assumes the bench commands frame arrivals and transmit draining
`timescale 1ns/1ns
module ssirq_far #(
    parameter int unsigned CW = 3  // fifo count width
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // from the register block
    input  wire logic          tx_push,
    input  wire logic [15:0]   tx_push_data,
    input  wire logic          rx_pop,
    input  wire logic          rx_store,
    // bench commands
    input  wire logic          frame_req,    // one frame arrives
    input  wire logic          drain_req,    // shifter sends tx entries
    // to the register block
    output logic [CW-1:0]      tx_fifo_count,
    output logic [CW-1:0]      rx_fifo_count,
    output logic [15:0]        rx_fifo_head,
    output logic [15:0]        last_tx,      // last pushed word, for the bench
    output logic               rx_frame_done,
    output logic               frame_in_flight
);
    // head carries the fill count so a stale value is caught
    assign rx_fifo_head    = 16'hc0d0 | 16'(rx_fifo_count);
    assign frame_in_flight = drain_req;  // shifter busy while draining
    // counters: pushes and stores add, drain and pops remove
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_fifo_count <= '0;
            rx_fifo_count <= '0;
            rx_frame_done <= 1'b0;
            last_tx       <= '0;
        end else begin
            rx_frame_done <= frame_req;
            rx_fifo_count <= rx_fifo_count + CW'(rx_store) - CW'(rx_pop);
            if (tx_push) begin
                tx_fifo_count <= tx_fifo_count + CW'(1);
                last_tx       <= tx_push_data;
            end else if (drain_req && tx_fifo_count != '0) begin
                tx_fifo_count <= tx_fifo_count - CW'(1);
            end
        end
    end
endmodule

// file: verification/testbench.sv
// self-checking bench of the status / prescale / interrupt register block
// assumes ssirq_far stands for the fifos; bus tasks act as an axi4-lite master
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module testbench;
    int fails = 0, total_checks = 0, cyc = 0, ticks = 0, t0;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic port_enable = 1, frame_req = 0, drain_req = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rd_v;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata;
    logic [15:0] tx_push_data, rx_fifo_head, last_tx;
    logic [2:0]  tx_fifo_count, rx_fifo_count;
    logic awready, wready, bvalid, arready, rvalid, tx_push, rx_pop, rx_store;
    logic serial_bit_clock, rx_frame_done, frame_in_flight;
    // small fifo and short time-out keep the run brief
    ssirq_regs #(.FIFO_DEPTH(4), .TIMEOUT_BITS(8), .IDENT_4(8'h5a), .IDENT_5(8'h3c)) DUT (.*);
    ssirq_far #(.CW(3)) far (.*);
    always #20 aclk = ~aclk;
    // watchdog and bit-clock pulse counter
    always @(posedge aclk) begin
        cyc++;
        ticks <= ticks + int'(serial_bit_clock);
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        resp = bresp;
        bready <= 0;
    endtask
    // read: hold rready until rvalid is sampled
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rd_v = rdata;
        resp = rresp;
        rready <= 0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] ex, input string nm);
        rd(a);
        `CHK(nm, ex, rd_v)
    endtask
    task automatic frames(input int n);
        repeat (n) begin
            @(posedge aclk) frame_req <= 1;
            @(posedge aclk) frame_req <= 0;
            repeat (3) @(posedge aclk);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rchk(ssirq_pkg::OFS_STATUS, 32'h3, "status");
        rchk(ssirq_pkg::OFS_RAW, 32'h8, "raw");
        rchk(ssirq_pkg::OFS_MASKED, 32'h0, "masked");
        rchk(ssirq_pkg::OFS_MASK, 32'h0, "mask");
        rchk(ssirq_pkg::OFS_IDENT4, 32'h5a, "ident");
        rchk(ssirq_pkg::OFS_IDENT5, 32'h3c, "ident 5");
        rd(12'h100);
        `CHK("unmapped", 2'b10, resp)
        wr(12'h100, 32'h0);
        `CHK("wr unmapped", 2'b10, resp)
        $display("test reset done");
        wr(ssirq_pkg::OFS_PRESCALE, 32'h7);
        rchk(ssirq_pkg::OFS_PRESCALE, 32'h6, "prescale");
        repeat (10) @(posedge aclk);
        t0 = ticks;
        repeat (60) @(posedge aclk);
        `CHK("ticks", 10, ticks - t0)
        port_enable <= 0;
        repeat (2) @(posedge aclk);
        t0 = ticks;
        repeat (30) @(posedge aclk);
        `CHK("ticks off", 0, ticks - t0)
        port_enable <= 1;
        wr(ssirq_pkg::OFS_MASK, 32'hf);
        rchk(ssirq_pkg::OFS_MASK, 32'hf, "mask");
        wr(ssirq_pkg::OFS_RAW, 32'h0);
        rchk(ssirq_pkg::OFS_RAW, 32'h8, "raw");
        wr(ssirq_pkg::OFS_MASK, 32'h3);
        rchk(ssirq_pkg::OFS_MASKED, 32'h0, "masked");
        $display("test registers done");
        for (int i = 0; i < 4; i++) wr(ssirq_pkg::OFS_DATA, 32'ha50 + i);
        @(posedge aclk);  // the last push reaches the fifo model one clock after the response
        `CHK("tx data", 16'ha53, last_tx)
        rchk(ssirq_pkg::OFS_STATUS, 32'h10, "status");
        rchk(ssirq_pkg::OFS_RAW, 32'h0, "raw");
        drain_req <= 1;
        repeat (4) @(posedge aclk);
        rchk(ssirq_pkg::OFS_STATUS, 32'h13, "status");
        drain_req <= 0;
        rchk(ssirq_pkg::OFS_STATUS, 32'h3, "status");
        $display("test transmit done");
        frames(4);
        rchk(ssirq_pkg::OFS_STATUS, 32'hf, "status");
        rchk(ssirq_pkg::OFS_RAW, 32'hc, "raw");
        frames(1);
        rchk(ssirq_pkg::OFS_MASKED, 32'h1, "masked");
        wr(ssirq_pkg::OFS_CLEAR, 32'h1);
        rchk(ssirq_pkg::OFS_RAW, 32'hc, "raw");
        repeat (80) @(posedge aclk);
        rchk(ssirq_pkg::OFS_RAW, 32'he, "raw");
        wr(ssirq_pkg::OFS_CLEAR, 32'h2);
        rchk(ssirq_pkg::OFS_RAW, 32'hc, "raw");
        rchk(ssirq_pkg::OFS_DATA, 32'hc0d4, "data");
        rchk(ssirq_pkg::OFS_STATUS, 32'h7, "status");
        $display("test receive done");
        results();
    end
endmodule
